// [core/lsr_status_regs.sv]
// Purpose: APB slave with four read-only link and chain status registers
// Assumes: Status inputs are synchronous to pclk; event inputs are one-cycle pulses
// Notes: Writes are accepted and ignored; unmapped addresses answer with pslverr
//
// How it works
// - Read-only byte holds block address of the latest double-error memory event
// - Six-bit current chain address in low bits, upper two bits read zero
// - Bit four shows hardware, not user control, owns the chain ports
// - Bits three to zero show live lower and upper transmitter, receiver enables
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module lsr_status_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory error event
    input wire logic ded_event,
    input wire logic [7:0] ded_block_addr,
    // Chain address
    input wire logic [5:0] dev_addr,
    // Baud control
    input wire logic comm_reset,
    input wire logic baud_write,
    input wire logic [1:0] baud_ctrl,
    // Tone and port enables
    input lsr_pkg::lsr_tone_s tone_in,
    input lsr_pkg::lsr_chain_s chain_in
);

    // ========================================
    // State and decode
    lsr_pkg::lsr_state_s st_ff;
    lsr_pkg::lsr_state_s nxt_st;
    lsr_pkg::lsr_baud_e baud;
    lsr_pkg::lsr_reg_e sel;
    logic setup;
    logic [7:0] rd_byte;

    // Decode once per cycle; setup marks the first cycle of a transfer
    assign sel = lsr_pkg::lsr_decode(paddr);
    assign setup = psel && !penable;

    // ========================================
    // Baud tracker
    lsr_baud_track u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .comm_reset(comm_reset),
        .baud_write(baud_write),
        .baud_ctrl(baud_ctrl),
        .baud(baud)
    );

    // ========================================
    // Read byte selection from the held status copies
    always_comb begin
        rd_byte = lsr_pkg::RST_BYTE;
        unique case (sel)
            lsr_pkg::REG_DED: begin
                rd_byte = st_ff.dbl_err_block;
            end
            lsr_pkg::REG_DEV: begin
                rd_byte = {2'b00, st_ff.dev_addr};
            end
            lsr_pkg::REG_COMM: begin
                rd_byte[lsr_pkg::UPPER_TONE_BIT] = st_ff.tone.upper_tone_active;
                rd_byte[lsr_pkg::LOWER_TONE_BIT] = st_ff.tone.lower_tone_active;
                rd_byte[lsr_pkg::BAUD_LSB +: 2] = baud;
            end
            lsr_pkg::REG_CHAIN: begin
                rd_byte[lsr_pkg::HW_OWNS_BIT] = st_ff.chain.hardware_owns_ports;
                rd_byte[lsr_pkg::LOWER_TX_BIT] = st_ff.chain.lower_tx_enabled;
                rd_byte[lsr_pkg::LOWER_RX_BIT] = st_ff.chain.lower_rx_enabled;
                rd_byte[lsr_pkg::UPPER_TX_BIT] = st_ff.chain.upper_tx_enabled;
                rd_byte[lsr_pkg::UPPER_RX_BIT] = st_ff.chain.upper_rx_enabled;
            end
            lsr_pkg::REG_NONE: begin
                rd_byte = lsr_pkg::RST_BYTE;
            end
            default: begin
                rd_byte = lsr_pkg::RST_BYTE;
            end
        endcase
    end

    // ========================================
    // Next state: status capture and APB handshake
    always_comb begin
        nxt_st = st_ff;
        // Keep the last failing block until a newer event replaces it
        if (ded_event) begin
            nxt_st.dbl_err_block = ded_block_addr;
        end
        nxt_st.dev_addr = dev_addr;
        nxt_st.tone = tone_in;
        nxt_st.chain = chain_in;
        unique case (st_ff.apb)
            lsr_pkg::APB_IDLE: begin
                nxt_st.pready = 1'b0;
                nxt_st.pslverr = 1'b0;
                // Answer in the first access cycle, read data sampled at setup
                if (setup) begin
                    nxt_st.apb = lsr_pkg::APB_ACK;
                    nxt_st.pready = 1'b1;
                    nxt_st.pslverr = (sel == lsr_pkg::REG_NONE);
                    nxt_st.prdata = pwrite ? lsr_pkg::RST_WORD : {24'h00_0000, rd_byte};
                end
            end
            lsr_pkg::APB_ACK: begin
                // Master completes at this edge since pready is already high
                if (psel && penable) begin
                    nxt_st.apb = lsr_pkg::APB_IDLE;
                    nxt_st.pready = 1'b0;
                    nxt_st.pslverr = 1'b0;
                end
            end
        endcase
    end

    // ========================================
    // State register, all fields reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;

    // ========================================
    // Checks
    ded_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        ded_event ##1 (!ded_event) [*2] |-> st_ff.dbl_err_block == $past(ded_block_addr, 2))
        else $error("double error block not held");

    ded_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_DED) |=>
        (prdata == {24'h00_0000, $past(st_ff.dbl_err_block)}))
        else $error("double error block read wrong");

    dev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_DEV) ##1 (!setup) |->
        (prdata[31:6] == 26'h0 && prdata[5:0] == $past(dev_addr, 2)))
        else $error("chain address read wrong");

    comm_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_COMM) |=>
        (prdata[1:0] == $past(baud) && prdata[31:4] == 28'h0))
        else $error("baud field read wrong");

    hw_own_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_CHAIN) |=>
        (prdata[4] == $past(chain_in.hardware_owns_ports, 2)))
        else $error("ownership bit read wrong");

    chain_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_CHAIN) |=>
        (prdata[3:0] == {$past(chain_in.lower_tx_enabled, 2), $past(chain_in.lower_rx_enabled, 2),
        $past(chain_in.upper_tx_enabled, 2), $past(chain_in.upper_rx_enabled, 2)}
        && prdata[31:5] == 27'h0))
        else $error("port enable bits read wrong");

    tone_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && sel == lsr_pkg::REG_COMM) |=>
        (prdata[3:2] == {$past(tone_in.upper_tone_active, 2), $past(tone_in.lower_tone_active, 2)}))
        else $error("tone flags read wrong");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pready) |=> pready ##1 (!pready || !(psel && penable)))
        else $error("apb answer timing wrong");

    apb_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pready) |=> (pslverr == (lsr_pkg::lsr_decode($past(paddr)) == lsr_pkg::REG_NONE)))
        else $error("unmapped address answer wrong");

endmodule

// [core/lsr_pkg.sv]
// Purpose: Shared constants and types for the link status register bank
// Assumes: 32-bit APB data, one aligned word per register, byte address = 4 * index
// Notes: All registers are read-only and reset to zero
package lsr_pkg;

    // ========================================
    // Bus widths
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ========================================
    // Register indexes as printed, byte address is four times the index
    localparam logic [9:0] IDX_DBL_ERR = 10'h2ba;
    localparam logic [9:0] IDX_DEV_ADDR = 10'h2bb;
    localparam logic [9:0] IDX_COMM = 10'h2bc;
    localparam logic [9:0] IDX_CHAIN = 10'h2bd;

    // ========================================
    // Field positions and widths
    localparam int unsigned DEV_ADDR_W = 6;
    localparam int unsigned BAUD_LSB = 0;
    localparam int unsigned LOWER_TONE_BIT = 2;
    localparam int unsigned UPPER_TONE_BIT = 3;
    localparam int unsigned UPPER_RX_BIT = 0;
    localparam int unsigned UPPER_TX_BIT = 1;
    localparam int unsigned LOWER_RX_BIT = 2;
    localparam int unsigned LOWER_TX_BIT = 3;
    localparam int unsigned HW_OWNS_BIT = 4;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ========================================
    // Enumerations
    typedef enum logic [1:0] {
        BAUD_125K = 2'b00,
        BAUD_250K = 2'b01,
        BAUD_500K = 2'b10,
        BAUD_1M = 2'b11
    } lsr_baud_e;

    typedef enum logic [2:0] {
        REG_NONE = 3'b000,
        REG_DED = 3'b001,
        REG_DEV = 3'b010,
        REG_COMM = 3'b011,
        REG_CHAIN = 3'b100
    } lsr_reg_e;

    typedef enum logic {
        APB_IDLE = 1'b0,
        APB_ACK = 1'b1
    } lsr_apb_e;

    // ========================================
    // Carriers
    typedef struct packed {
        logic hardware_owns_ports;
        logic lower_tx_enabled;
        logic lower_rx_enabled;
        logic upper_tx_enabled;
        logic upper_rx_enabled;
    } lsr_chain_s;

    typedef struct packed {
        logic upper_tone_active;
        logic lower_tone_active;
    } lsr_tone_s;

    typedef struct packed {
        lsr_apb_e apb;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] dbl_err_block;
        logic [5:0] dev_addr;
        lsr_tone_s tone;
        lsr_chain_s chain;
    } lsr_state_s;

    typedef struct packed {
        lsr_baud_e baud;
    } lsr_baud_state_s;

    // ========================================
    // Address decode, used by the read path and its checks
    function automatic lsr_reg_e lsr_decode(input logic [11:0] addr);
        lsr_reg_e sel;
        sel = REG_NONE;
        if (addr == {IDX_DBL_ERR, 2'b00}) begin
            sel = REG_DED;
        end else if (addr == {IDX_DEV_ADDR, 2'b00}) begin
            sel = REG_DEV;
        end else if (addr == {IDX_COMM, 2'b00}) begin
            sel = REG_COMM;
        end else if (addr == {IDX_CHAIN, 2'b00}) begin
            sel = REG_CHAIN;
        end
        return sel;
    endfunction

endpackage

// [core/lsr_baud_track.sv]
// Purpose: Holds the active baud rate code shown in the comm status register
// Assumes: Reset and write strobes are one-cycle pulses synchronous to pclk
// Notes: Value only moves on a strobe, so a control field change alone is not seen
`timescale 1ns/10ps
module lsr_baud_track (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Update sources
    input wire logic comm_reset,
    input wire logic baud_write,
    input wire logic [1:0] baud_ctrl,
    // Status out
    output lsr_pkg::lsr_baud_e baud
);

    // ========================================
    // State
    lsr_pkg::lsr_baud_state_s st_ff;
    lsr_pkg::lsr_baud_state_s nxt_st;

    // Take the control field on either strobe, else hold
    always_comb begin
        nxt_st = st_ff;
        if (comm_reset || baud_write) begin
            nxt_st.baud = lsr_pkg::lsr_baud_e'(baud_ctrl);
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= lsr_pkg::lsr_baud_state_s'(lsr_pkg::BAUD_125K);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign baud = st_ff.baud;

    // ========================================
    // Checks
    baud_update_a: assert property (@(posedge pclk) disable iff (!presetn)
        (comm_reset || baud_write) |=> (baud == $past(baud_ctrl)))
        else $error("baud code did not follow control field");

    baud_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(comm_reset || baud_write) |=> $stable(baud))
        else $error("baud code moved without a strobe");

endmodule

// [bench/lsr_testbench.sv]
// Purpose: Self-checking bench for the link status register bank
// Assumes: APB slave answers in its own time, status levels seen one cycle late
// Notes: Table rows cover all baud codes; holds, writes, errors, reset follow
`timescale 1ns/10ps
module testbench;
    // ========================================
    // Signals
    typedef struct packed {
        logic [7:0] ded;
        logic [5:0] dev;
        logic [1:0] baud;
        lsr_pkg::lsr_tone_s tone;
        lsr_pkg::lsr_chain_s chain;
        logic [7:0] e_comm;
        logic [7:0] e_chain;
    } lsr_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ded_event = 1'b0;
    logic [7:0] ded_block_addr = 8'h00;
    logic [5:0] dev_addr = 6'h00;
    logic comm_reset = 1'b0;
    logic baud_write = 1'b0;
    logic [1:0] baud_ctrl = 2'h0;
    lsr_pkg::lsr_tone_s tone_in = 2'h0;
    lsr_pkg::lsr_chain_s chain_in = 5'h00;
    logic [31:0] rdata_q;
    logic err_q;
    lsr_row_s rows [4];
    lsr_row_s r;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    lsr_status_regs i_lsr_status_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ded_event(ded_event),
        .ded_block_addr(ded_block_addr), .dev_addr(dev_addr), .comm_reset(comm_reset),
        .baud_write(baud_write), .baud_ctrl(baud_ctrl), .tone_in(tone_in),
        .chain_in(chain_in)
    );

    // ========================================
    // Clock and hang guard, run needs about a hundred cycles
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ========================================
    // Shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Caller sits just after an edge; request is held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the cycle ceiling ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata_q = prdata;
        err_q = pslverr;
    endtask
    // No release inside apb, so reads can run back to back
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rdata_q, e);
        chk({31'h0, err_q}, {31'h0, ee});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        rows[0] = {8'hff, 6'h3f, 2'h0, 2'h2, 5'h10, 8'h08, 8'h10};
        rows[1] = {8'h01, 6'h01, 2'h1, 2'h1, 5'h08, 8'h05, 8'h08};
        rows[2] = {8'h5a, 6'h2a, 2'h2, 2'h0, 5'h04, 8'h02, 8'h04};
        rows[3] = {8'ha5, 6'h15, 2'h3, 2'h3, 5'h03, 8'h0f, 8'h03};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            r = rows[i];
            ded_block_addr <= r.ded;
            dev_addr <= r.dev;
            baud_ctrl <= r.baud;
            tone_in <= r.tone;
            chain_in <= r.chain;
            ded_event <= 1'b1;
            baud_write <= 1'b1;
            @(posedge pclk);
            ded_event <= 1'b0;
            baud_write <= 1'b0;
            repeat (3) @(posedge pclk);
            rd(12'hae8, {24'h0, r.ded}, 1'b0);
            rd(12'haec, {26'h0, r.dev}, 1'b0);
            rd(12'haf0, {24'h0, r.e_comm}, 1'b0);
            rd(12'haf4, {24'h0, r.e_chain}, 1'b0);
            idle();
            $display("row %0d done", i);
        end
        // Sources move without strobes, held values must not follow
        ded_block_addr <= 8'h33;
        baud_ctrl <= 2'h0;
        repeat (3) @(posedge pclk);
        rd(12'hae8, 32'ha5, 1'b0);
        rd(12'haf0, 32'h0f, 1'b0);
        idle();
        comm_reset <= 1'b1;
        @(posedge pclk);
        comm_reset <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(12'haf0, 32'h0c, 1'b0);
        idle();
        $display("hold test done");
        // Write to a read-only register, then read an unmapped word
        apb(1'b1, 12'haec, 32'hffff_ffff);
        chk({31'h0, err_q}, 32'h0);
        idle();
        rd(12'haec, 32'h15, 1'b0);
        rd(12'haf8, 32'h0, 1'b1);
        idle();
        $display("access test done");
        // Mid-run reset with nonzero held block and baud values
        baud_ctrl <= 2'h2;
        baud_write <= 1'b1;
        @(posedge pclk);
        baud_write <= 1'b0;
        dev_addr <= 6'h00;
        tone_in <= 2'h0;
        chain_in <= 5'h00;
        presetn <= 1'b0;
        @(posedge pclk);
        chk({prdata[30:0], pready}, 32'h0);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'hae8, 32'h0, 1'b0);
        rd(12'haec, 32'h0, 1'b0);
        rd(12'haf0, 32'h0, 1'b0);
        rd(12'haf4, 32'h0, 1'b0);
        idle();
        $display("reset test done");
        end_of_test();
    end
endmodule
